/* File: design/kbm_pkg.sv */
// kbm_pkg: constants for the host/controller keyboard-style mailbox.
// assumes both register ports run on the single system clock.
//
// Summary of operation
// - host status port mirrors controller status, read-only
// - user status bits writable only by controller
// - bus reset forces user bit two low
// - aux write sets, data write clears aux
// - host command write sets C/D, data clears
// - any host input write sets in_full
// - in_full drives controller interrupt when enabled
// - controller inbound read clears in_full, interrupt
// - full flags survive bus reset, power-down
// - controller data or aux write sets out_full
// - host data read clears out_full, pulses interrupt
// - controller window offsets 0h,4h,8h,Ch,14h
// - controller reads last host byte at 0h
// - controller write 0h loads outbound, sets out_full
// - host data read clears host output interrupts
// - activate low powers down host interface
package kbm_pkg;

  // ------------------------------------------------------------------
  // host runtime offsets
  // ------------------------------------------------------------------
  localparam logic [2:0] KBM_HOST_DATA_OFS = 3'h0;
  localparam logic [2:0] KBM_HOST_STAT_OFS = 3'h4;

  // ------------------------------------------------------------------
  // controller private offsets
  // ------------------------------------------------------------------
  localparam logic [4:0] KBM_EC_DATA_OFS  = 5'h00;
  localparam logic [4:0] KBM_EC_STAT_OFS  = 5'h04;
  localparam logic [4:0] KBM_EC_KCTL_OFS  = 5'h08;
  localparam logic [4:0] KBM_EC_AUX_OFS   = 5'h0C;
  localparam logic [4:0] KBM_EC_PRIMARY_OUT_FULL_IRQ_OFS = 5'h14;

  // ------------------------------------------------------------------
  // status bit positions
  // ------------------------------------------------------------------
  localparam int KBM_ST_OUT_FULL     = 0;
  localparam int KBM_ST_IN_FULL      = 1;
  localparam int KBM_ST_USER_LOW     = 2;
  localparam int KBM_ST_CMD_DATA     = 3;
  localparam int KBM_ST_USER_MID     = 4;
  localparam int KBM_ST_AUX_OUT_FULL = 5;
  localparam int KBM_ST_USER_HIGH_LO = 6;
  localparam int KBM_ST_USER_HIGH_HI = 7;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] KBM_BYTE_RST = 8'h00;
  localparam logic [1:0] KBM_UHI_RST  = 2'h0;
  localparam logic       KBM_BIT_RST  = 1'b0;
  localparam logic       KBM_PIN_IDLE = 1'b1;

endpackage

/* File: design/kbm_sync3.sv */
// kbm_sync3: three-flop input synchroniser with agreement filter.
// assumes an asynchronous pin input; output idles at KBM_PIN_IDLE.
`timescale 1ns/1ps
module kbm_sync3 (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);
  import kbm_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic agree;

  // first stage feeds only the second stage
  assign agree = (s2_q == s3_q);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q    <= KBM_PIN_IDLE;
      s2_q    <= KBM_PIN_IDLE;
      s3_q    <= KBM_PIN_IDLE;
      level_o <= KBM_PIN_IDLE;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        level_o <= s3_q;
      end
    end
  end

endmodule // kbm_sync3

/* File: design/kbm_mailbox.sv */
// kbm_mailbox: byte mailbox between bus host and embedded controller.
// assumes host and controller strobes are one-cycle pulses on clk_i.
`timescale 1ns/1ps
module kbm_mailbox (
  // clock and system reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // bus reset pin and activate control
  input  wire logic       bus_reset_n_i,
  input  wire logic       activate_i,
  // host runtime port
  input  wire logic [2:0] host_addr_i,
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic [7:0] host_wdata_i,
  output logic      [7:0] host_rdata_o,
  // controller private port
  input  wire logic [4:0] ec_addr_i,
  input  wire logic       ec_wr_i,
  input  wire logic       ec_rd_i,
  input  wire logic [7:0] ec_wdata_i,
  output logic      [7:0] ec_rdata_o,
  // interrupts
  input  wire logic       in_full_irq_en_i,
  output logic            in_full_irq_o,
  output logic            out_full_irq_o,
  output logic            host_kbd_irq_o,
  output logic            host_aux_irq_o
);
  import kbm_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [7:0] inbound_byte_q;
  logic [7:0] outbound_byte_q;
  logic [1:0] user_bits_high_q;
  logic       user_bit_mid_q;
  logic       user_bit_low_q;
  logic       aux_out_full_q;
  logic       cmd_data_q;
  logic       in_full_q;
  logic       out_full_q;
  logic       primary_out_full_irq_q;
  logic       aux_irq_q;
  logic       bus_reset_lvl;
  logic [7:0] status;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire h_data  = host_addr_i == KBM_HOST_DATA_OFS;
  wire h_stat  = host_addr_i == KBM_HOST_STAT_OFS;
  wire h_wr_d  = activate_i && host_wr_i && h_data;
  wire h_wr_c  = activate_i && host_wr_i && h_stat;
  // only data reads have side effects
  wire h_rd_d  = activate_i && host_rd_i && h_data;
  wire h_wr    = h_wr_d || h_wr_c;
  wire e_data  = ec_addr_i == KBM_EC_DATA_OFS;
  wire e_stat  = ec_addr_i == KBM_EC_STAT_OFS;
  wire e_aux   = ec_addr_i == KBM_EC_AUX_OFS;
  wire e_wr_d  = ec_wr_i && e_data;
  wire e_wr_a  = ec_wr_i && e_aux;
  wire e_wr_s  = ec_wr_i && e_stat;
  wire e_rd_d  = ec_rd_i && e_data;
  wire e_load  = e_wr_d || e_wr_a;
  wire bus_rst = !bus_reset_lvl;

  // ------------------------------------------------------------------
  // bus reset pin synchroniser
  // ------------------------------------------------------------------
  kbm_sync3 u_bus_rst_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (bus_reset_n_i),
    .level_o   (bus_reset_lvl)
  );

  // one status vector for both views
  assign status = {user_bits_high_q, aux_out_full_q, user_bit_mid_q,
                   cmd_data_q, user_bit_low_q, in_full_q, out_full_q};

  assign in_full_irq_o  = in_full_q && in_full_irq_en_i;
  assign host_kbd_irq_o = primary_out_full_irq_q;
  assign host_aux_irq_o = aux_irq_q;

  // ------------------------------------------------------------------
  // read data muxes
  // ------------------------------------------------------------------
  // keyboard control and the irq register read as zero here
  wire [7:0] ec_rmux = e_data ? inbound_byte_q :
                       e_stat ? status : KBM_BYTE_RST;
  wire [7:0] h_rmux  = !activate_i ? KBM_BYTE_RST :
                       h_data ? outbound_byte_q :
                       h_stat ? status : KBM_BYTE_RST;

  // ------------------------------------------------------------------
  // data bytes and read registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inbound_byte_q  <= KBM_BYTE_RST;
      outbound_byte_q <= KBM_BYTE_RST;
      host_rdata_o    <= KBM_BYTE_RST;
      ec_rdata_o      <= KBM_BYTE_RST;
    end else begin
      if (h_wr) begin
        inbound_byte_q <= host_wdata_i;
      end
      if (e_load) begin
        outbound_byte_q <= ec_wdata_i;
      end
      if (host_rd_i) begin
        host_rdata_o <= h_rmux;
      end
      if (ec_rd_i) begin
        ec_rdata_o <= ec_rmux;
      end
    end
  end

  // ------------------------------------------------------------------
  // flags; a set in the same cycle as its clear wins
  // ------------------------------------------------------------------
  // only system reset and defined accesses touch the flags
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_full_q              <= KBM_BIT_RST;
      out_full_q             <= KBM_BIT_RST;
      cmd_data_q             <= KBM_BIT_RST;
      aux_out_full_q         <= KBM_BIT_RST;
      primary_out_full_irq_q <= KBM_BIT_RST;
      aux_irq_q              <= KBM_BIT_RST;
      out_full_irq_o         <= KBM_BIT_RST;
    end else begin
      // set on host write, cleared by inbound read
      if (h_wr) begin
        in_full_q <= 1'b1;
      end else if (e_rd_d) begin
        in_full_q <= 1'b0;
      end
      if (h_wr_c) begin
        cmd_data_q <= 1'b1;
      end else if (h_wr_d) begin
        cmd_data_q <= 1'b0;
      end
      // set on load, cleared by host data read
      if (e_load) begin
        out_full_q <= 1'b1;
      end else if (h_rd_d) begin
        out_full_q <= 1'b0;
      end
      // aux marker follows the last load kind
      if (e_wr_a) begin
        aux_out_full_q <= 1'b1;
      end else if (e_wr_d) begin
        aux_out_full_q <= 1'b0;
      end
      if (e_wr_d) begin
        primary_out_full_irq_q <= 1'b1;
      end else if (h_rd_d) begin
        primary_out_full_irq_q <= 1'b0;
      end
      if (e_wr_a) begin
        aux_irq_q <= 1'b1;
      end else if (h_rd_d) begin
        aux_irq_q <= 1'b0;
      end
      out_full_irq_o <= h_rd_d;
    end
  end

  // ------------------------------------------------------------------
  // user bits, controller alias only
  // ------------------------------------------------------------------
  // writable only at the controller status offset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      user_bits_high_q <= KBM_UHI_RST;
      user_bit_mid_q   <= KBM_BIT_RST;
      user_bit_low_q   <= KBM_BIT_RST;
    end else begin
      if (e_wr_s) begin
        user_bits_high_q <=
          ec_wdata_i[KBM_ST_USER_HIGH_HI:KBM_ST_USER_HIGH_LO];
        user_bit_mid_q   <= ec_wdata_i[KBM_ST_USER_MID];
      end
      // bus reset beats a controller write
      if (bus_rst) begin
        user_bit_low_q <= 1'b0;
      end else if (e_wr_s) begin
        user_bit_low_q <= ec_wdata_i[KBM_ST_USER_LOW];
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_in_full_set;
    h_wr |=> in_full_q && in_full_irq_o == in_full_irq_en_i;
  endproperty
  a_in_full_set: assert property (p_in_full_set)
    else $error("in_full not set after host write");

  property p_in_full_clr;
    e_rd_d && !h_wr |=> !in_full_q && !in_full_irq_o;
  endproperty
  a_in_full_clr: assert property (p_in_full_clr)
    else $error("in_full not cleared by controller read");

  property p_cmd_flag;
    h_wr |=> in_full_q && cmd_data_q == $past(h_wr_c);
  endproperty
  a_cmd_flag: assert property (p_cmd_flag)
    else $error("command marker wrong");

  property p_out_full_set;
    e_load |=> out_full_q && outbound_byte_q == $past(ec_wdata_i);
  endproperty
  a_out_full_set: assert property (p_out_full_set)
    else $error("out_full or outbound byte wrong after load");

  property p_out_full_clr;
    h_rd_d && !e_load |=> !out_full_q && out_full_irq_o
      && !host_kbd_irq_o && !host_aux_irq_o;
  endproperty
  a_out_full_clr: assert property (p_out_full_clr)
    else $error("host data read side effects missing");

  property p_aux_flag;
    e_wr_a |=> aux_out_full_q && out_full_q && host_aux_irq_o;
  endproperty
  a_aux_flag: assert property (p_aux_flag)
    else $error("aux marker not set");

  property p_aux_clr;
    e_wr_d |=> !aux_out_full_q && out_full_q && host_kbd_irq_o;
  endproperty
  a_aux_clr: assert property (p_aux_clr)
    else $error("aux marker not cleared by data load");

  property p_stat_read;
    host_rd_i && h_stat && activate_i && !host_wr_i && !ec_wr_i
      && !ec_rd_i && !bus_rst
      |=> host_rdata_o == $past(status) && $stable(status);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read disturbed flags");

  property p_user_low;
    bus_rst |=> !user_bit_low_q;
  endproperty
  a_user_low: assert property (p_user_low)
    else $error("user bit low survived bus reset");

  property p_inactive;
    !activate_i && host_wr_i && !ec_rd_i |=> $stable(in_full_q);
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("inactive interface took a host write");

  property p_inbound;
    h_wr |=> inbound_byte_q == $past(host_wdata_i);
  endproperty
  a_inbound: assert property (p_inbound)
    else $error("host byte not captured");

  property p_ec_read;
    e_rd_d |=> ec_rdata_o == $past(inbound_byte_q);
  endproperty
  a_ec_read: assert property (p_ec_read)
    else $error("controller read wrong inbound byte");

endmodule // kbm_mailbox

/* File: verif/kbm_host_model.sv */
// kbm_host_model: host side of the runtime port, byte reads and writes.
// assumes tasks are called from a bench on the same clk_i.
`timescale 1ns/1ps
module kbm_host_model (
  // clock
  input  wire logic       clk_i,
  // runtime port
  output logic      [2:0] host_addr_o,
  output logic            host_wr_o,
  output logic            host_rd_o,
  output logic      [7:0] host_wdata_o,
  input  wire logic [7:0] host_rdata_i
);
  initial begin
    host_addr_o  = 3'h0;
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
    host_wdata_o = 8'hA5;
  end
  // one-cycle strobe; the byte is there one cycle later
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_i);
    host_addr_o = a;
    host_rd_o   = 1'b1;
    @(negedge clk_i);
    host_rd_o   = 1'b0;
    d           = host_rdata_i;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] s;
    int         n;
    s = 8'h02;
    n = 0;
    while (s[1] === 1'b1 && n < 40) begin
      rd(3'h4, s);
      n++;
    end
    @(negedge clk_i);
    host_addr_o  = a;
    host_wdata_o = d;
    host_wr_o    = 1'b1;
    @(negedge clk_i);
    host_wr_o    = 1'b0;
    // released data must not look like a held byte
    host_wdata_o = ~d;
  endtask
endmodule // kbm_host_model

/* File: verif/kbm_mailbox_tb.sv */
// kbm_mailbox_tb: self-checking bench for the keyboard-style mailbox.
// assumes kbm_pkg is compiled first; host side is kbm_host_model.
`timescale 1ns/1ps
module kbm_mailbox_tb;
  import kbm_pkg::*;
  logic clk_i, reset_n_i, bus_reset_n_i, activate_i, irq_en;
  logic [2:0] h_addr;
  logic h_wr, h_rd, ec_wr, ec_rd, ifi, ofi, kbi, axi;
  logic [7:0] h_wd, h_rd_d, ec_wd, ec_rd_d, r, d, st;
  logic [4:0] ec_addr;
  int num_errors, checks_done;
  kbm_mailbox dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .bus_reset_n_i(bus_reset_n_i), .activate_i(activate_i),
    .host_addr_i(h_addr), .host_wr_i(h_wr), .host_rd_i(h_rd),
    .host_wdata_i(h_wd), .host_rdata_o(h_rd_d), .ec_addr_i(ec_addr),
    .ec_wr_i(ec_wr), .ec_rd_i(ec_rd), .ec_wdata_i(ec_wd),
    .ec_rdata_o(ec_rd_d), .in_full_irq_en_i(irq_en),
    .in_full_irq_o(ifi), .out_full_irq_o(ofi),
    .host_kbd_irq_o(kbi), .host_aux_irq_o(axi));
  kbm_host_model host (.clk_i(clk_i), .host_addr_o(h_addr),
    .host_wr_o(h_wr), .host_rd_o(h_rd), .host_wdata_o(h_wd),
    .host_rdata_i(h_rd_d));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic logic [7:0] merge_user(logic [7:0] s, logic [7:0] u);
    return (s & 8'h2B) | (u & 8'hD4);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic ecw(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk_i);
    ec_addr = a;
    ec_wd   = v;
    ec_wr   = 1'b1;
    @(negedge clk_i);
    ec_wr   = 1'b0;
    ec_wd   = ~v;
  endtask
  task automatic ecr(input logic [4:0] a, output logic [7:0] v);
    @(negedge clk_i);
    ec_addr = a;
    ec_rd   = 1'b1;
    @(negedge clk_i);
    ec_rd   = 1'b0;
    v       = ec_rd_d;
  endtask
  task automatic chk_st();
    ecr(5'h04, r);
    chk(r, st);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(25ns * 20000);
    num_errors++;
    give_verdict();
  end
  initial begin
    reset_n_i     = 1'b0;
    bus_reset_n_i = 1'b1;
    activate_i    = 1'b1;
    irq_en        = 1'b0;
    ec_addr       = 5'h00;
    ec_wr         = 1'b0;
    ec_rd         = 1'b0;
    ec_wd         = 8'h00;
    num_errors    = 0;
    checks_done   = 0;
    st            = 8'h00;
    void'($urandom(73263));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    chk_st();
    host.rd(3'h4, r);
    chk(r, st);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d      = (i == 0) ? 8'hFF : 8'($urandom);
      irq_en = i[1];
      host.wr(i[0] ? 3'h4 : 3'h0, d);
      st[1] = 1'b1;
      st[3] = i[0];
      chk_st();
      chkb(ifi, i[1]);
      ecr(5'h00, r);
      chk(r, d);
      st[1] = 1'b0;
      chk_st();
      chkb(ifi, 1'b0);
    end
    $display("inbound done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 1) ? 8'h00 : 8'($urandom);
      ecw(i[0] ? 5'h0C : 5'h00, d);
      st[0] = 1'b1;
      st[5] = i[0];
      chk_st();
      chk({6'h00, axi, kbi}, i[0] ? 8'h02 : 8'h01);
      host.rd(3'h4, r);
      host.rd(3'h4, r);
      chk(r, st);
      chkb(ofi, 1'b0);
      host.rd(3'h0, r);
      chk(r, d);
      chkb(ofi, 1'b1);
      chk({6'h00, axi, kbi}, 8'h00);
      st[0] = 1'b0;
      chk_st();
      chkb(ofi, 1'b0);
    end
    $display("outbound done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      ecw(5'h04, d);
      st = merge_user(st, d);
      chk_st();
      host.rd(3'h4, r);
      chk(r, st);
    end
    ecw(5'h04, 8'hFF);
    st = merge_user(st, 8'hFF);
    @(negedge clk_i);
    bus_reset_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    st[2] = 1'b0;
    chk_st();
    bus_reset_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    ecw(5'h04, 8'h04);
    st = merge_user(st, 8'h04);
    chk_st();
    $display("user bits done");
    activate_i = 1'b0;
    host.wr(3'h0, 8'h5A);
    chk_st();
    host.rd(3'h4, r);
    chk(r, 8'h00);
    ecw(5'h00, 8'hC3);
    st[0] = 1'b1;
    st[5] = 1'b0;
    host.rd(3'h0, r);
    chk(r, 8'h00);
    chk_st();
    activate_i = 1'b1;
    host.rd(3'h0, r);
    chk(r, 8'hC3);
    st[0] = 1'b0;
    chk_st();
    $display("activate done");
    ecw(5'h08, 8'hFF);
    ecw(5'h14, 8'hFF);
    chk_st();
    ecr(5'h08, r);
    chk(r, 8'h00);
    ecr(5'h14, r);
    chk(r, 8'h00);
    ecr(5'h1C, r);
    chk(r, 8'h00);
    $display("window done");
    // system reset in mid-run clears both bytes and every flag
    host.wr(3'h0, 8'h3C);
    ecw(5'h00, 8'h96);
    @(negedge clk_i);
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    st = 8'h00;
    chk_st();
    chkb(kbi, 1'b0);
    ecr(5'h00, r);
    chk(r, 8'h00);
    host.rd(3'h0, r);
    chk(r, 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule // kbm_mailbox_tb
